// ==== rtl/slb_ctrl.sv ====
// Host-side sequencer that runs the link self-test and collects its result
//
// Local design decisions: the address-and-strobe port and the register offsets.
module slb_ctrl #(
  parameter int CNT_W = 32
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // Software register port
  input  wire logic [3:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  output logic             irq_out,
  // Device pins
  input  wire logic        pass_in,
  input  wire logic        lock_in,
  output logic             ser_self_test_request_out,
  output logic             des_self_test_request_out
);

  // Timer must hold the 16-bit settle wait and fit the 32-bit length register
  if (CNT_W < 16 || CNT_W > 32) begin : g_bad_cnt_w
    $error("CNT_W must be 16..32");
  end

  slb_pkg::slb_state_type state;
  slb_pkg::slb_state_type next_state;
  slb_pkg::slb_pins_type  pins;
  slb_pkg::slb_pins_type  next_pins;

  logic [CNT_W-1:0]      len;
  logic [15:0]           settle;
  logic [CNT_W-1:0]      timer;
  logic [31:0]           err_cnt;
  logic                  verdict;
  logic                  valid;
  logic                  pass_d;
  logic                  lock_d;
  logic [slb_pkg::IRQ_W-1:0] irq_st;
  logic [slb_pkg::IRQ_W-1:0] irq_mask;

  // Register strobes, decoded once
  wire wr_ctrl  = wr_in && (addr_in == slb_pkg::ADDR_CTRL);
  wire wr_irq   = wr_in && (addr_in == slb_pkg::ADDR_IRQ);
  wire wr_mask  = wr_in && (addr_in == slb_pkg::ADDR_MASK);
  wire wr_len   = wr_in && (addr_in == slb_pkg::ADDR_LENLO);
  wire wr_set   = wr_in && (addr_in == slb_pkg::ADDR_SETTLE);
  wire start    = wr_ctrl && wdata_in[slb_pkg::CTRL_START];
  wire abort    = wr_ctrl && wdata_in[slb_pkg::CTRL_ABORT];
  wire timer_z  = (timer == '0);

  // Low pulses on pass counted only while receiver is checking
  wire err_pulse = (state == slb_pkg::ST_RUN) && pass_d && !pass_in;
  wire unlock_ev = lock_d && !lock_in;
  wire done_ev;

  // Sequencer: serializer first, receiver second, reverse at the end
  always_comb begin
    next_state = state;
    next_pins  = pins;
    case (state)
      slb_pkg::ST_IDLE: begin
        if (start) begin
          next_state      = slb_pkg::ST_SERUP;
          next_pins.ser_req = 1'b1;
        end
      end
      slb_pkg::ST_SERUP: begin
        // Wait for the stream to settle and the receiver to see test mode
        if (abort) begin
          next_state      = slb_pkg::ST_SERDN;
          next_pins.ser_req = 1'b0;
        end else if (timer_z) begin
          next_state      = slb_pkg::ST_RUN;
          next_pins.des_req = 1'b1;
        end
      end
      slb_pkg::ST_RUN: begin
        // Receiver request stays high for the programmed test length plus one cycle
        if (timer_z || abort) begin
          next_state      = slb_pkg::ST_DESDN;
          next_pins.des_req = 1'b0;
        end
      end
      slb_pkg::ST_DESDN: begin
        if (timer_z) begin
          next_state      = slb_pkg::ST_SERDN;
          next_pins.ser_req = 1'b0;
        end
      end
      slb_pkg::ST_SERDN: begin
        if (timer_z) next_state = slb_pkg::ST_IDLE;
      end
      default: begin
        next_state = slb_pkg::ST_IDLE;
        next_pins  = '0;
      end
    endcase
  end

  assign done_ev = (state == slb_pkg::ST_DESDN) && timer_z;

  // State, pins and phase timer; every phase is counted, so the link clock must keep running
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state <= slb_pkg::ST_IDLE;
      pins  <= '0;
      timer <= '0;
    end else begin
      state <= next_state;
      pins  <= next_pins;
      if (next_state != state) begin
        timer <= (next_state == slb_pkg::ST_RUN) ? len : CNT_W'(settle);
      end else if (!timer_z) begin
        timer <= timer - 1'b1;
      end
    end
  end

  // Result capture: verdict sampled after receiver freezes it
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      err_cnt <= 32'h0;
      verdict <= 1'b0;
      valid   <= 1'b0;
    end else if (start && state == slb_pkg::ST_IDLE) begin
      err_cnt <= 32'h0;
      valid   <= 1'b0;
    end else begin
      if (err_pulse) err_cnt <= err_cnt + 32'h1;
      if (done_ev) begin
        verdict <= pass_in;
        valid   <= 1'b1;
      end
    end
  end

  // Pin history for edge detection
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      pass_d <= 1'b1;
      lock_d <= 1'b0;
    end else begin
      pass_d <= pass_in;
      lock_d <= lock_in;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      len      <= CNT_W'(slb_pkg::LEN_RESET);
      settle   <= slb_pkg::SETTLE_RESET;
      irq_mask <= '0;
    end else begin
      if (wr_len) len <= CNT_W'(wdata_in);
      if (wr_set) settle <= wdata_in[15:0];
      if (wr_mask) irq_mask <= wdata_in[slb_pkg::IRQ_W-1:0];
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  wire [slb_pkg::IRQ_W-1:0] irq_set = {unlock_ev, err_pulse, done_ev};
  wire [slb_pkg::IRQ_W-1:0] irq_clr = wr_irq ? wdata_in[slb_pkg::IRQ_W-1:0] : '0;
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      irq_st  <= '0;
      irq_out <= 1'b0;
    end else begin
      irq_st  <= (irq_st & ~irq_clr) | irq_set;
      irq_out <= |(((irq_st & ~irq_clr) | irq_set) & irq_mask);
    end
  end

  // Read mux
  wire [31:0] status_w = {28'h0, lock_in, valid, verdict, (state != slb_pkg::ST_IDLE)};
  wire [31:0] rd_mux =
    (addr_in == slb_pkg::ADDR_CTRL)   ? 32'h0 :
    (addr_in == slb_pkg::ADDR_STATUS) ? status_w :
    (addr_in == slb_pkg::ADDR_IRQ)    ? {29'h0, irq_st} :
    (addr_in == slb_pkg::ADDR_MASK)   ? {29'h0, irq_mask} :
    (addr_in == slb_pkg::ADDR_LENLO)  ? 32'(len) :
    (addr_in == slb_pkg::ADDR_ERRCNT) ? err_cnt :
    (addr_in == slb_pkg::ADDR_SETTLE) ? {16'h0, settle} : 32'h0;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) rdata_out <= 32'h0;
    else rdata_out <= rd_in ? rd_mux : 32'h0;
  end

  assign ser_self_test_request_out = pins.ser_req;
  assign des_self_test_request_out = pins.des_req;

  // Receiver request only ever high while serializer request is high
  a_req_order: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    des_self_test_request_out |-> ser_self_test_request_out)
    else $error("receiver request high without serializer request");

  // Serializer request may only drop after receiver request already low
  a_ser_drop: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $fell(ser_self_test_request_out) |-> !$past(des_self_test_request_out))
    else $error("serializer request dropped before receiver request");

  sequence s_run_entry;
    state == slb_pkg::ST_SERUP && timer_z && !abort;
  endsequence
  a_des_raise: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_run_entry |=> des_self_test_request_out && ser_self_test_request_out)
    else $error("receiver request not raised after settle");

  a_verdict_cap: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    done_ev |=> valid && (verdict == $past(pass_in)))
    else $error("verdict not captured from pass");

  a_err_count: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    err_pulse && !(start && state == slb_pkg::ST_IDLE) |=> err_cnt == $past(err_cnt) + 32'h1)
    else $error("payload error pulse not counted");

  a_run_stop: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == slb_pkg::ST_RUN && timer_z |=> !des_self_test_request_out)
    else $error("receiver request held past test length");

  a_new_clear: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    start && state == slb_pkg::ST_IDLE |=> !valid && err_cnt == 32'h0)
    else $error("new test did not clear result");

  a_lock_irq: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    unlock_ev |=> irq_st[slb_pkg::IRQ_UNLOCK])
    else $error("lock loss not flagged");

  sequence s_test_end;
    state == slb_pkg::ST_DESDN && timer_z;
  endsequence

  // Start from idle raises only the serializer request
  a_start_ser: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    start && state == slb_pkg::ST_IDLE |=> ser_self_test_request_out && !des_self_test_request_out)
    else $error("start did not raise serializer request alone");

  // Receiver request rises only with serializer request already up
  a_ser_first: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(des_self_test_request_out) |-> $past(ser_self_test_request_out))
    else $error("receiver request raised before serializer request");

  // Serializer request still up when receiver request falls
  a_des_first: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    $fell(des_self_test_request_out) |-> ser_self_test_request_out)
    else $error("receiver request fell after serializer request");

  // End of the post-test wait drops the serializer request
  a_ser_release: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_test_end |=> !ser_self_test_request_out)
    else $error("serializer request not released after test");

  // Test end raises the done event
  a_done_irq: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_test_end |=> irq_st[slb_pkg::IRQ_DONE])
    else $error("test end not flagged");

  // Each counted pass pulse raises the error event
  a_err_irq: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    err_pulse |=> irq_st[slb_pkg::IRQ_ERRPLS])
    else $error("error pulse not flagged");

  // Run phase is loaded with the programmed length
  a_len_load: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_run_entry |=> timer == $past(len))
    else $error("run phase not loaded with test length");

  // Idle keeps both request pins low
  a_idle_quiet: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == slb_pkg::ST_IDLE |-> !ser_self_test_request_out && !des_self_test_request_out)
    else $error("request pin high while idle");

  // Abort while settling releases the serializer without a receiver test
  a_abort_up: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state == slb_pkg::ST_SERUP && abort |=> !ser_self_test_request_out && !des_self_test_request_out)
    else $error("abort during settle not honoured");

  // Outside the run phase the error count changes only when a new start clears it
  a_err_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    state != slb_pkg::ST_RUN && !(start && state == slb_pkg::ST_IDLE) |=> err_cnt == $past(err_cnt))
    else $error("error count moved outside the run phase");

  // Held result changes only at test end or a new start
  a_verdict_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !done_ev && !(start && state == slb_pkg::ST_IDLE) |=>
      verdict == $past(verdict) && valid == $past(valid))
    else $error("held verdict changed unexpectedly");

  // Lock flag only set by a lock loss and only cleared by a write of one
  a_lock_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !unlock_ev && !(wr_irq && wdata_in[slb_pkg::IRQ_UNLOCK]) |=>
      irq_st[slb_pkg::IRQ_UNLOCK] == $past(irq_st[slb_pkg::IRQ_UNLOCK]))
    else $error("lock flag changed without cause");

  // Interrupt line follows the unmasked flags one cycle behind the mask
  a_irq_line: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    irq_out == |(irq_st & $past(irq_mask)))
    else $error("interrupt line disagrees with flags");

  // Read data is zero except in the cycle after a read strobe
  a_rdata_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data present without read strobe");

endmodule : slb_ctrl

// ==== rtl/slb_pkg.sv ====
// Constants, register map and carrier types for the link self-test controller
// Overview of operation
// - A running input pixel clock must be supplied throughout the self-test.
// - Test mode travels in control bits; receiver then blanks colour and sync outputs.
// - Receiver compares each payload against the expected pattern while requested.
// - Each payload with 1 to 24 bit errors pulses pass low half a clock.
// - Receiver request falling stops checking and freezes the verdict on pass.
// - Frozen verdict is high for no errors, low for one or more.
// - Verdict holds until a new test, a receiver reset or power-down.
// - Test length equals how long the receiver request is held high; here it is held for the programmed length plus one cycle.
// - After the receiver test ends, drop serializer request; video then resumes.
// - Raise serializer request before receiver request; lower them in reverse order.
// - A pass bounds error rate to one over 24 times clock rate times duration.
// - Receiver drives lock low when embedded clock bits do not rebuild the clock.
// - Controller may count pass low pulses to estimate the payload error rate.
package slb_pkg;

  // Register offsets on the software port
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ    = 4'h2;
  localparam logic [3:0] ADDR_MASK   = 4'h3;
  localparam logic [3:0] ADDR_LENLO  = 4'h4;
  localparam logic [3:0] ADDR_ERRCNT = 4'h5;
  localparam logic [3:0] ADDR_SETTLE = 4'h6;

  // Control register bits
  localparam int CTRL_START = 0;
  localparam int CTRL_ABORT = 1;

  // Status register bits
  localparam int ST_BUSY    = 0;
  localparam int ST_VERDICT = 1;
  localparam int ST_VALID   = 2;
  localparam int ST_LOCK    = 3;

  // Interrupt bits
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_ERRPLS = 1;
  localparam int IRQ_UNLOCK = 2;
  localparam int IRQ_W      = 3;

  // Reset values
  localparam logic [31:0] LEN_RESET    = 32'h0000_1000;
  localparam logic [15:0] SETTLE_RESET = 16'h0100;

  // Pin drive bundle towards both ends of the link
  typedef struct packed {
    logic ser_req;
    logic des_req;
  } slb_pins_type;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_SERUP  = 5'b00010,
    ST_RUN    = 5'b00100,
    ST_DESDN  = 5'b01000,
    ST_SERDN  = 5'b10000
  } slb_state_type;

endpackage : slb_pkg

// ==== verif/slb_rx_model.sv ====
// Behavioural receiver end of the link, facing the self-test controller
module slb_rx_model (
  // Clock and request pins
  input  wire logic clk_in,
  input  wire logic ser_req_in,
  input  wire logic des_req_in,
  // Bench commands
  input  wire logic inject_in,
  input  wire logic lock_ok_in,
  // Receiver pins
  output logic      pass_out,
  output logic      lock_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic err_seen;

  // Lock follows the bench's view of clock recovery
  // Framing bits are not modelled: a good lock stands for a rebuilt clock
  assign lock_out = lock_ok_in;

  initial begin
    pass_out = 1'b1;
    err_seen = 1'b0;
  end

  // New test drops the held result and realigns the checker
  always @(posedge des_req_in) begin
    err_seen = 1'b0;
    pass_out = 1'b1;
  end

  // Errored payload: low for half a period, straddling a rising edge
  always @(negedge clk_in) begin
    if (des_req_in && ser_req_in && inject_in) begin
      err_seen = 1'b1;
      #2.5 pass_out = 1'b0;
      #5 pass_out = 1'b1;
    end
  end

  // Checking stops; verdict frozen until the next test
  always @(negedge des_req_in) pass_out = ~err_seen;
endmodule : slb_rx_model

// ==== verif/slb_ctrl_bench.sv ====
// Self-checking bench for the link self-test controller
module slb_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_in, reset_n_in, wr_in, rd_in, pass_in, lock_in;
  logic [3:0]  addr_in;
  logic [31:0] wdata_in, rdata_out, d;
  logic        irq_out, ser, des, inject, lock_ok;
  int          fails, n_tests, n;
  wire  [1:0]  pins = {des, ser};

  slb_ctrl dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .irq_out(irq_out), .pass_in(pass_in), .lock_in(lock_in),
    .ser_self_test_request_out(ser), .des_self_test_request_out(des));

  slb_rx_model rx (.clk_in(clk_in), .ser_req_in(ser), .des_req_in(des),
    .inject_in(inject), .lock_ok_in(lock_ok), .pass_out(pass_in), .lock_out(lock_in));

  // Free-running clock, never stopped during a test
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task check(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : rd

  // Bounded wait on a request pin; a hang ends the run
  task wait_pin(input int which, input logic val);
    int i;
    for (i = 0; i < 200 && pins[which] !== val; i++) begin
      @(posedge clk_in);
      #1;
    end
    if (i == 200) begin
      fails++;
      tally_and_finish();
    end
  endtask : wait_pin

  // One full test; pulses injected on alternate cycles so each is seen
  task run_test(input int nerr);
    wr(slb_pkg::ADDR_CTRL, 32'h1);
    wait_pin(0, 1'b1);
    check(des, 1'b0);
    rd(slb_pkg::ADDR_STATUS);
    check(d, 32'h9);
    wait_pin(1, 1'b1);
    check(ser, 1'b1);
    for (n = 0; des === 1'b1 && n < 300; n++) begin
      inject <= (n < 2 * nerr) && n[0];
      @(posedge clk_in);
      #1;
    end
    if (n == 300) begin
      fails++;
      tally_and_finish();
    end
    check(n, 32'd21);
    check(ser, 1'b1);
    wait_pin(0, 1'b0);
    check(pass_in, nerr == 0);
    repeat (6) @(posedge clk_in);
    rd(slb_pkg::ADDR_STATUS);
    check(d, {28'h0, 4'hc} | ((nerr == 0) << 1));
    if (nerr > 0) begin
      rd(slb_pkg::ADDR_ERRCNT);
      check(d, nerr);
    end
    rd(slb_pkg::ADDR_IRQ);
    check(d, (nerr > 0) ? 32'h3 : 32'h1);
    check(irq_out, 1'b1);
    wr(slb_pkg::ADDR_IRQ, 32'h3);
    rd(slb_pkg::ADDR_IRQ);
    check({d[31:0], irq_out}, 33'h0);
  endtask : run_test

  initial begin
    fails = 0;
    n_tests = 0;
    {wr_in, rd_in, inject} = 3'h0;
    lock_ok = 1'b1;
    addr_in = 4'h0;
    wdata_in = 32'h0;
    reset_n_in = 1'b0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    check({ser, des, irq_out}, 3'h0);
    rd(slb_pkg::ADDR_LENLO);
    check(d, slb_pkg::LEN_RESET);
    rd(slb_pkg::ADDR_SETTLE);
    check(d, 32'h100);
    rd(4'hf);
    check(d, 32'h0);
    wr(slb_pkg::ADDR_SETTLE, 32'h4);
    wr(slb_pkg::ADDR_LENLO, 32'd20);
    wr(slb_pkg::ADDR_MASK, 32'h7);
    // Errored run first, then a clean one that must drop the old verdict
    run_test(3);
    run_test(0);
    check(ser, 1'b0);
    // Abort while the stream settles: receiver request never raised
    wr(slb_pkg::ADDR_CTRL, 32'h1);
    wait_pin(0, 1'b1);
    wr(slb_pkg::ADDR_CTRL, 32'h2);
    check(des, 1'b0);
    wait_pin(0, 1'b0);
    check({des, irq_out}, 2'h0);
    // Lock loss raises its event; masking silences the line
    lock_ok <= 1'b0;
    repeat (3) @(posedge clk_in);
    rd(slb_pkg::ADDR_IRQ);
    check({d, irq_out}, 33'h9);
    wr(slb_pkg::ADDR_MASK, 32'h0);
    rd(slb_pkg::ADDR_STATUS);
    check({d, irq_out}, {32'h2, 1'b0});
    tally_and_finish();
  end
endmodule : slb_ctrl_bench
